/* File: core/gcg_pkg.sv */
package gcg_pkg;

  localparam int NGEN  = 4;
  localparam int NSRC  = 4;
  localparam int SRC_W = 2;
  localparam int DIV_W = 8;
  localparam int AW    = 6;

  // Source indices.
  localparam logic [SRC_W-1:0] SRC_RC8 = 2'h0;
  localparam logic [SRC_W-1:0] SRC_PLL = 2'h1;

  // Register byte offsets.
  localparam logic [AW-1:0] OFS_CTRL    = 6'h00;
  localparam logic [AW-1:0] OFS_GEN_SEL = 6'h04;
  localparam logic [AW-1:0] OFS_GEN_CFG = 6'h08;
  localparam logic [AW-1:0] OFS_GEN_EN  = 6'h0c;
  localparam logic [AW-1:0] OFS_SRC     = 6'h10;
  localparam logic [AW-1:0] OFS_PLL_CFG = 6'h14;
  localparam logic [AW-1:0] OFS_PLL_OUT = 6'h18;
  localparam logic [AW-1:0] OFS_PLL_REF = 6'h1c;
  localparam logic [AW-1:0] OFS_FLASH   = 6'h20;
  localparam logic [AW-1:0] OFS_STATUS  = 6'h24;

  // Field positions.
  localparam int CTRL_INIT    = 0;
  localparam int CTRL_START   = 1;
  localparam int GEN_EN_BIT   = 0;
  localparam int GEN_RUN_BIT  = 1;
  localparam int GEN_SW_BIT   = 2;
  localparam int SRC_OD_LSB   = 4;
  localparam int SRC_RDY_LSB  = 8;
  localparam int ST_RC8_USED  = 0;
  localparam int ST_START_OK  = 1;
  localparam int FLASH_W      = 4;

  typedef struct packed {
    logic             pin_en;
    logic             run_sleep;
    logic             off_high;
    logic [DIV_W-1:0] div;
    logic [SRC_W-1:0] src;
  } gcg_gen_cfg_type;

  typedef struct packed {
    logic [10:0] ref_div;
    logic [1:0]  filter;
    logic [1:0]  lock_time;
    logic [1:0]  ref_sel;
    logic        low_power;
    logic        fast_wake;
    logic        lock_bypass;
    logic        run_stby;
  } gcg_pll_cfg_type;

  // Reset values.
  localparam gcg_gen_cfg_type GEN_CFG_RST = '0;
  localparam gcg_pll_cfg_type PLL_CFG_RST = '0;
  localparam logic [NSRC-1:0] SRC_EN_RST  = 4'h1;
  localparam logic [NSRC-1:0] SRC_OD_RST  = 4'h2;
  localparam logic [31:0]     PLL_OUT_RST = 32'h02dc_6c00;
  localparam logic [31:0]     PLL_REF_RST = 32'h0000_8000;
  localparam logic [FLASH_W-1:0] FLASH_RST = 4'h0;

  typedef enum logic [2:0] {
    GS_OFF   = 3'b001,
    GS_RUN   = 3'b010,
    GS_DRAIN = 3'b100
  } gcg_gen_state_type;

endpackage

/* File: core/gcg_top.sv */
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module gcg_top
  import gcg_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Avalon-MM slave
  input  wire logic [AW-1:0]      avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [3:0]         avs_byteenable,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // Clock sources
  input  wire logic [NSRC-1:0]    src_clk,
  input  wire logic [NSRC-1:0]    src_ready,
  output logic      [NSRC-1:0]    src_enable,
  output logic      [NSRC-1:0]    src_req,
  output gcg_pll_cfg_type         pll_cfg,
  output logic      [31:0]        pll_out_hz,
  output logic      [31:0]        pll_ref_hz,
  // Power state
  input  wire logic               sleep,
  input  wire logic               standby,
  // Generator outputs
  output logic      [NGEN-1:0]    gen_clk,
  output logic      [NGEN-1:0]    gen_pin_out,
  output logic      [NGEN-1:0]    gen_pin_oe,
  // Flash
  output logic      [FLASH_W-1:0] flash_wait_states
);

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Synchronisers for asynchronous inputs.
  logic [NSRC-1:0] clk_s1, clk_s2, clk_s3;
  logic [NSRC-1:0] rdy_s1, rdy_s2;
  logic [1:0]      pwr_s1, pwr_s2;

  always_ff @(posedge clk) begin
    clk_s1 <= src_clk;
    clk_s2 <= clk_s1;
    clk_s3 <= clk_s2;
    rdy_s1 <= src_ready;
    rdy_s2 <= rdy_s1;
    pwr_s1 <= {standby, sleep};
    pwr_s2 <= pwr_s1;
  end

  wire logic [NSRC-1:0] src_lvl  = clk_s2;
  wire logic [NSRC-1:0] src_edge = clk_s2 ^ clk_s3;
  wire logic            sleep_s  = pwr_s2[0];
  wire logic            stby_s   = pwr_s2[1];

  // Software-visible state.
  gcg_gen_cfg_type   gen_cfg [NGEN];
  logic [NGEN-1:0]   gen_en;
  logic [SRC_W-1:0]  gen_sel;
  logic [NSRC-1:0]   src_od;

  // Generator state gathered from the generate loop.
  logic [NGEN-1:0]   gen_active;
  logic [NGEN-1:0]   gen_busy;
  logic [NGEN-1:0]   gen_runs;
  logic [NGEN-1:0]   gen_sw;
  logic [SRC_W-1:0]  gen_cur [NGEN];

  for (genvar g = 0; g < NGEN; g++) begin : gen_g
    gcg_gen_state_type st;
    logic [SRC_W-1:0]  cur;
    logic [DIV_W-1:0]  cnt;
    logic              clk_q;
    logic              pin_q;
    logic              oe_q;

    wire gcg_gen_cfg_type c = gen_cfg[g];
    // Sleep gating uses the run-in-sleep option.
    wire logic active = gen_en[g] & ~(sleep_s & ~c.run_sleep);
    // A zero divider behaves as one: source passes through.
    wire logic [DIV_W-1:0] divm1 =
      (c.div == '0) ? '0 : c.div - 1'b1;
    wire logic tick = src_edge[cur];
    wire logic wrap = (cnt >= divm1);
    // New source must be ready and low; a switch also needs the output low.
    wire logic can_take = rdy_s2[c.src] & ~src_lvl[c.src];
    wire logic do_start = active & can_take;
    wire logic do_sw = (c.src != cur) & can_take & ~clk_q;

    always_ff @(posedge clk) begin
      if (!nrst) begin
        st    <= GS_OFF;
        cur   <= SRC_RC8;
        cnt   <= '0;
        clk_q <= 1'b0;
      end else begin
        case (st)
          GS_OFF: begin
            cnt <= '0;
            if (do_start) begin
              st    <= GS_RUN;
              cur   <= c.src;
              clk_q <= 1'b0;
            end else begin
              clk_q <= c.off_high;
            end
          end
          GS_RUN, GS_DRAIN: begin
            if (!active) begin
              st <= GS_DRAIN;
            end else begin
              st <= GS_RUN;
            end
            if (!active && !clk_q) begin
              // Stop only on a low output to avoid a runt pulse.
              st    <= GS_OFF;
              clk_q <= c.off_high;
            end else if (active && do_sw) begin
              cur <= c.src;
              cnt <= '0;
            end else if (tick) begin
              cnt <= wrap ? '0 : cnt + 1'b1;
              if (wrap) begin
                clk_q <= ~clk_q;
              end
            end
          end
          default: begin
            st    <= GS_OFF;
            clk_q <= 1'b0;
          end
        endcase
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        pin_q <= 1'b0;
        oe_q  <= 1'b0;
      end else begin
        pin_q <= clk_q & c.pin_en;
        oe_q  <= c.pin_en;
      end
    end

    assign gen_clk[g]     = clk_q;
    assign gen_pin_out[g] = pin_q;
    assign gen_pin_oe[g]  = oe_q;
    assign gen_active[g]  = active;
    assign gen_busy[g]    = (st != GS_OFF);
    assign gen_runs[g]    = (st == GS_RUN);
    assign gen_sw[g]      = (st != GS_OFF) & (c.src != cur);
    assign gen_cur[g]     = cur;
  end

  // Source demand: selected and in-use sources are both requested.
  logic [NSRC-1:0] need;
  logic            rc8_used;

  always_comb begin
    need = '0;
    for (int g = 0; g < NGEN; g++) begin
      for (int s = 0; s < NSRC; s++) begin
        if (gen_active[g] && gen_cfg[g].src == s[SRC_W-1:0]) begin
          need[s] = 1'b1;
        end
        if (gen_busy[g] && gen_cur[g] == s[SRC_W-1:0]) begin
          need[s] = 1'b1;
        end
      end
    end
    rc8_used = need[SRC_RC8];
  end

  wire logic [NSRC-1:0] stby_block =
    (stby_s & ~pll_cfg.run_stby) ? (NSRC'(1) << SRC_PLL) : '0;
  wire logic [NSRC-1:0] next_src_req =
    src_enable & (~src_od | need) & ~stby_block;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      src_req <= '0;
    end else begin
      src_req <= next_src_req;
    end
  end

  // Bus: one wait cycle, then the request commits on the low edge.
  wire logic req    = avs_read | avs_write;
  wire logic commit = avs_write & ~avs_waitrequest &
                      (avs_byteenable == 4'hf);
  wire logic [31:0] wd = avs_writedata;

  wire logic w_ctrl  = commit & hit(avs_address, OFS_CTRL);
  wire logic w_sel   = commit & hit(avs_address, OFS_GEN_SEL);
  wire logic w_gcfg  = commit & hit(avs_address, OFS_GEN_CFG);
  wire logic w_gen   = commit & hit(avs_address, OFS_GEN_EN);
  wire logic w_src   = commit & hit(avs_address, OFS_SRC);
  wire logic w_pcfg  = commit & hit(avs_address, OFS_PLL_CFG);
  wire logic w_pout  = commit & hit(avs_address, OFS_PLL_OUT);
  wire logic w_pref  = commit & hit(avs_address, OFS_PLL_REF);
  wire logic w_flash = commit & hit(avs_address, OFS_FLASH);
  wire logic do_init  = w_ctrl & wd[CTRL_INIT];
  wire logic do_start = w_ctrl & wd[CTRL_START];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gen_en            <= '0;
      gen_sel           <= '0;
      src_enable        <= SRC_EN_RST;
      src_od            <= SRC_OD_RST;
      pll_cfg           <= PLL_CFG_RST;
      pll_out_hz        <= PLL_OUT_RST;
      pll_ref_hz        <= PLL_REF_RST;
      flash_wait_states <= FLASH_RST;
    end else begin
      if (do_init) begin
        gen_en <= '0;
      end else if (do_start) begin
        gen_en <= '1;
      end else if (w_gen) begin
        gen_en[gen_sel] <= wd[GEN_EN_BIT];
      end
      if (w_sel) begin
        gen_sel <= wd[SRC_W-1:0];
      end
      if (w_src) begin
        src_enable <= wd[NSRC-1:0];
        src_od     <= wd[SRC_OD_LSB +: NSRC];
      end
      if (w_pcfg) begin
        pll_cfg <= gcg_pll_cfg_type'(wd[$bits(gcg_pll_cfg_type)-1:0]);
        src_enable[SRC_PLL] <= 1'b1;
      end
      if (w_pout) begin
        pll_out_hz <= wd;
      end
      if (w_pref) begin
        pll_ref_hz <= wd;
      end
      if (w_flash) begin
        flash_wait_states <= wd[FLASH_W-1:0];
      end
    end
  end

  // Configuration stores leave the enable untouched.
  for (genvar g = 0; g < NGEN; g++) begin : cfg_g
    always_ff @(posedge clk) begin
      if (!nrst || do_init) begin
        gen_cfg[g] <= GEN_CFG_RST;
      end else if (w_gcfg && gen_sel == SRC_W'(g)) begin
        gen_cfg[g] <= gcg_gen_cfg_type'(wd[$bits(gcg_gen_cfg_type)-1:0]);
      end
    end
  end

  wire gcg_gen_cfg_type sel_cfg = gen_cfg[gen_sel];
  wire logic [31:0] rd_gen = {29'h0, gen_sw[gen_sel],
    gen_busy[gen_sel], gen_en[gen_sel]};
  wire logic [31:0] rd_src = {20'h0, rdy_s2, src_od, src_enable};
  wire logic [31:0] rd_st  = {30'h0, &gen_runs, rc8_used};

  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      OFS_GEN_SEL: rd_mux = {30'h0, gen_sel};
      OFS_GEN_CFG: rd_mux = 32'(sel_cfg);
      OFS_GEN_EN:  rd_mux = rd_gen;
      OFS_SRC:     rd_mux = rd_src;
      OFS_PLL_CFG: rd_mux = 32'(pll_cfg);
      OFS_PLL_OUT: rd_mux = pll_out_hz;
      OFS_PLL_REF: rd_mux = pll_ref_hz;
      OFS_FLASH:   rd_mux = 32'(flash_wait_states);
      OFS_STATUS:  rd_mux = rd_st;
      default:     rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule

/* File: verification/gcg_properties.sv */
`timescale 1ns/1ps
module gcg_properties
  import gcg_pkg::*;
(
  // Bus side
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic [AW-1:0]       avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_writedata,
  input wire logic                avs_waitrequest,
  // Clock side
  input wire logic [NSRC-1:0]     src_enable,
  input wire logic [NSRC-1:0]     src_req,
  input wire gcg_pll_cfg_type     pll_cfg,
  input wire logic [NGEN-1:0]     gen_clk,
  input wire logic [NGEN-1:0]     gen_pin_out,
  input wire logic [NGEN-1:0]     gen_pin_oe,
  input wire logic [FLASH_W-1:0]  flash_wait_states
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire wr_ok = avs_write & ~avs_waitrequest & (&avs_byteenable);
  sequence s_init;
    wr_ok && avs_address == OFS_CTRL && avs_writedata[CTRL_INIT];
  endsequence
  sequence s_start;
    wr_ok && avs_address == OFS_CTRL && avs_writedata[1:0] == 2'h2;
  endsequence
  AST_ANSWER: assert property ((avs_read | avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus not answered");
  AST_ONE_WAIT: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  AST_RST: assert property ($rose(nrst) |-> gen_clk == '0 && pll_cfg == '0
    && gen_pin_oe == '0 && src_enable == 4'h1) else $error("bad defaults");
  AST_PIN_QUIET: assert property (gen_pin_out ==
    ($past(gen_clk) & gen_pin_oe)) else $error("pin output wrong");
  AST_FLASH: assert property ($changed(flash_wait_states) && $past(nrst)
    |-> $past(wr_ok && avs_address == OFS_FLASH)) else $error("flash moved");
  AST_PLL_ON: assert property (wr_ok && avs_address == OFS_PLL_CFG
    |=> src_enable[1]) else $error("loop not enabled");
  AST_INIT: assert property (s_init |-> ##[1:600] (gen_clk == '0)[*8])
    else $error("clock left running");
  AST_START: assert property (s_start |-> ##[1:600] gen_clk != '0)
    else $error("start-up idle");
  AST_REQ: assert property (gen_clk != '0 |-> src_req != '0)
    else $error("source not requested");
endmodule

/* File: verification/gcg_src_model.sv */
`timescale 1ns/1ps
module gcg_src_model
  import gcg_pkg::*;
#(
  parameter int WARM = 6
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // Requests
  input  wire logic [NSRC-1:0] src_enable,
  input  wire logic [NSRC-1:0] src_req,
  // Sources
  output logic      [NSRC-1:0] src_clk,
  output logic      [NSRC-1:0] src_ready
);
  logic [3:0] warm [NSRC];
  logic [2:0] cnt [NSRC];
  // A dropped source halts low at once, so an early release loses the clock.
  always_ff @(posedge clk) begin
    for (int i = 0; i < NSRC; i++) begin
      if (!nrst || !(src_enable[i] && src_req[i])) begin
        warm[i] <= 4'h0;
        cnt[i] <= 3'h0;
        src_clk[i] <= 1'b0;
        src_ready[i] <= 1'b0;
      end else if (warm[i] < 4'(WARM)) begin
        warm[i] <= warm[i] + 4'h1;
      end else begin
        src_ready[i] <= 1'b1;
        cnt[i] <= (cnt[i] == 3'(i + 1)) ? 3'h0 : cnt[i] + 3'h1;
        if (cnt[i] == 3'(i + 1))
          src_clk[i] <= ~src_clk[i];
      end
    end
  end
endmodule

/* File: verification/tb_generic_clock_generator_control.sv */
`timescale 1ns/1ps
module tb_generic_clock_generator_control;
  import gcg_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [AW-1:0]     avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [31:0]       avs_writedata = '0;
  logic              sleep = 1'b0;
  logic              standby = 1'b0;
  logic              avs_waitrequest;
  logic [31:0]       avs_readdata, pll_out_hz, pll_ref_hz, rd;
  logic [NSRC-1:0]   src_clk, src_ready, src_enable, src_req;
  logic [NGEN-1:0]   gen_clk, gen_pin_out, gen_pin_oe;
  logic [FLASH_W-1:0] flash_wait_states;
  gcg_pll_cfg_type   pll_cfg;
  int                fail_count = 0;
  int                num_checks = 0;
  int                cg, cs;
  localparam logic [AW-1:0] DA [5] = '{OFS_GEN_CFG, OFS_PLL_CFG,
    OFS_PLL_OUT, OFS_PLL_REF, 6'h3c};
  localparam logic [31:0] DE [5] = '{32'h0, 32'h0, PLL_OUT_RST,
    PLL_REF_RST, 32'h0};

  always #10 clk = ~clk;

  gcg_top DUT (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_clk(src_clk), .src_ready(src_ready), .src_enable(src_enable),
    .src_req(src_req), .pll_cfg(pll_cfg), .pll_out_hz(pll_out_hz),
    .pll_ref_hz(pll_ref_hz), .sleep(sleep), .standby(standby),
    .gen_clk(gen_clk), .gen_pin_out(gen_pin_out),
    .gen_pin_oe(gen_pin_oe), .flash_wait_states(flash_wait_states));
  gcg_src_model u_src (.clk(clk), .nrst(nrst), .src_enable(src_enable),
    .src_req(src_req), .src_clk(src_clk), .src_ready(src_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // A wait that used up its bound ends the run as a failure.
  task automatic give_up(input logic hit);
    if (hit) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // Rising edges of generator k and of source 0 over a fixed window.
  task automatic count(input int k);
    logic pg, ps;
    cg = 0;
    cs = 0;
    pg = gen_clk[k];
    ps = src_clk[0];
    repeat (120) begin
      @(posedge clk);
      cg += int'(gen_clk[k] & ~pg);
      cs += int'(src_clk[0] & ~ps);
      pg = gen_clk[k];
      ps = src_clk[0];
    end
  endtask

  task automatic t_defaults();
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, DA[i], '0);
      check(rd, DE[i]);
    end
    bus(1'b0, OFS_SRC, '0);
    check({24'h0, rd[7:0]}, 32'h21);
    check(pll_out_hz, PLL_OUT_RST);
    check(pll_ref_hz, PLL_REF_RST);
    check(32'(pll_cfg), 32'h0);
    $display("defaults done");
  endtask

  task automatic t_enable();
    bus(1'b1, OFS_GEN_SEL, 32'h1);
    bus(1'b1, OFS_GEN_CFG, 32'h0);
    count(1);
    check(cg, 0);
    bus(1'b0, OFS_GEN_EN, '0);
    check(rd[0], 1'b0);
    bus(1'b1, OFS_GEN_EN, 32'h1);
    count(1);
    count(1);
    check(32'(cg > 10 && cg >= cs - 1 && cg <= cs + 1), 32'h1);
    bus(1'b0, OFS_GEN_EN, '0);
    check(rd[0], 1'b1);
    sleep <= 1'b1;
    count(1);
    count(1);
    check(cg, 0);
    sleep <= 1'b0;
    bus(1'b1, OFS_GEN_EN, 32'h0);
    count(1);
    count(1);
    check({cg[30:0], gen_clk[1]}, 32'h0);
    bus(1'b0, OFS_GEN_EN, '0);
    check(rd[0], 1'b0);
    $display("enable done");
  endtask

  task automatic t_start_init();
    avs_byteenable <= 4'h3;
    bus(1'b1, OFS_FLASH, 32'h7);
    avs_byteenable <= 4'hf;
    check(flash_wait_states, 4'h0);
    bus(1'b1, OFS_FLASH, 32'h7);
    check(flash_wait_states, 4'h7);
    bus(1'b1, OFS_CTRL, 32'h2);
    rd = '0;
    for (int n = 0; n < 30 && rd[1] !== 1'b1; n++)
      bus(1'b0, OFS_STATUS, '0);
    give_up(rd[1] !== 1'b1);
    check(rd[1:0], 2'h3);
    for (int k = 0; k < NGEN; k++) begin
      count(k);
      check(32'(cg > 10), 32'h1);
    end
    bus(1'b1, OFS_CTRL, 32'h1);
    for (int k = 0; k < NGEN; k++) begin
      bus(1'b1, OFS_GEN_SEL, 32'(k));
      bus(1'b0, OFS_GEN_EN, '0);
      check(rd[0], 1'b0);
      bus(1'b0, OFS_GEN_CFG, '0);
      check(rd, 32'h0);
      count(k);
      check(cg, 0);
    end
    $display("start-up and init done");
  endtask

  task automatic t_switch();
    bus(1'b1, OFS_SRC, 32'h31);
    bus(1'b1, OFS_GEN_SEL, 32'h1);
    bus(1'b1, OFS_GEN_EN, 32'h1);
    count(1);
    check(src_req[1:0], 2'h1);
    bus(1'b1, OFS_PLL_CFG, 32'h0);
    check(src_enable[1], 1'b1);
    bus(1'b1, OFS_GEN_CFG, {30'h0, SRC_PLL});
    for (int n = 0; n < 20 && src_req[1] !== 1'b1; n++)
      @(posedge clk);
    give_up(src_req[1] !== 1'b1);
    check({src_ready[1], src_req[1:0]}, 3'h3);
    for (int n = 0; n < 200 && src_req[0] !== 1'b0; n++)
      @(posedge clk);
    give_up(src_req[0] !== 1'b0);
    check(src_ready[1], 1'b1);
    count(1);
    check({31'(cg > 10), src_req[1]}, 32'h3);
    bus(1'b0, OFS_STATUS, '0);
    check(rd[0], 1'b0);
    bus(1'b1, OFS_GEN_CFG, 32'h1001);
    count(1);
    check(32'(gen_pin_oe), 32'h2);
    check(32'(cg > 10), 32'h1);
    $display("switch done");
  endtask

  task automatic t_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check({gen_clk, gen_pin_oe}, 8'h0);
    bus(1'b0, OFS_FLASH, '0);
    check(rd, 32'h0);
    bus(1'b1, OFS_PLL_CFG, 32'h0);
    bus(1'b1, OFS_SRC, 32'h3);
    @(posedge clk);
    check(src_req[1], 1'b1);
    standby <= 1'b1;
    repeat (6) @(posedge clk);
    check(src_req[1], 1'b0);
    bus(1'b1, OFS_PLL_CFG, 32'h1);
    repeat (2) @(posedge clk);
    check(src_req[1], 1'b1);
    standby <= 1'b0;
    $display("mid-run reset and standby done");
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_enable();
    t_start_init();
    t_switch();
    t_reset();
    print_verdict();
  end
endmodule

bind gcg_top gcg_properties u_props (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .src_enable(src_enable),
  .src_req(src_req), .pll_cfg(pll_cfg), .gen_clk(gen_clk),
  .gen_pin_out(gen_pin_out), .gen_pin_oe(gen_pin_oe),
  .flash_wait_states(flash_wait_states));
